// file: verilog/sync_serial_fifo_regs.sv
// Synchronous serial port: FIFOs, status, prescaler, interrupt flags and shifter
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defs.svh"
module sync_serial_fifo_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // Serial clock pin
    input wire logic ser_clk_in,
    output logic ser_clk_out,
    output logic ser_clk_oe,
    // Select pin, active low
    input wire logic sel_n_in,
    output logic sel_n_out,
    output logic sel_n_oe,
    // Serial data pins
    input wire logic ser_din,
    output logic ser_dout,
    output logic ser_dout_oe,
    // Interrupt
    output logic irq
);
    import ssp_pkg::*;

    ssp_pkg::ser_state_e state;
    logic [3:0] size_m1;
    logic [7:0] serial_clock_rate_factor;
    logic ctrl_enable;
    logic ctrl_slave;
    logic [7:0] prescale_divisor;
    logic [3:0] irq_enable_mask;
    logic overrun_raw_flag;
    logic rx_timeout_raw_flag;
    logic [6:0] pre_cnt;
    logic half_pre;
    logic [7:0] scr_cnt;
    logic half_tick;
    logic [6:0] timeout_cnt;
    logic clk_meta;
    logic clk_sync;
    logic clk_prev;
    logic sel_meta;
    logic sel_sync;
    logic din_meta;
    logic din_sync;
    logic [15:0] tx_shift;
    logic [15:0] rx_shift;
    logic [15:0] rx_word;
    logic [3:0] bit_cnt;
    logic need_load;
    logic tx_pop;
    logic rx_push;
    logic [15:0] tx_head;
    logic [15:0] rx_head;
    logic [3:0] tx_count;
    logic [3:0] rx_count;
    logic [15:0] tx_aligned;
    logic tx_push;
    logic rx_pop;
    logic tx_fifo_empty_flag;
    logic tx_fifo_not_full_flag;
    logic rx_fifo_not_empty_flag;
    logic rx_fifo_full_flag;
    logic controller_active_flag;
    logic [3:0] irq_raw_status;
    logic [3:0] irq_masked_status;
    logic clk_rise;
    logic clk_fall;
    logic clear_wr;

    assign tx_push = wr_en && (addr == `ADDR_DATA) && tx_fifo_not_full_flag;
    assign rx_pop = rd_en && (addr == `ADDR_DATA) && rx_fifo_not_empty_flag;
    assign clear_wr = wr_en && (addr == `ADDR_CLEAR);

    sync_fifo tx_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .push(tx_push),
        .push_data(wdata[15:0]),
        .pop(tx_pop),
        .head(tx_head),
        .count(tx_count)
    );

    sync_fifo rx_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .push(rx_push),
        .push_data(rx_word),
        .pop(rx_pop),
        .head(rx_head),
        .count(rx_count)
    );

    assign tx_fifo_empty_flag = (tx_count == 4'h0);
    assign tx_fifo_not_full_flag = (tx_count != `FIFO_DEPTH);
    assign rx_fifo_not_empty_flag = (rx_count != 4'h0);
    assign rx_fifo_full_flag = (rx_count == `FIFO_DEPTH);
    assign controller_active_flag = (state != st_idle) || !tx_fifo_empty_flag;
    assign irq_raw_status = {(tx_count <= `FIFO_HALF), (rx_count >= `FIFO_HALF),
        rx_timeout_raw_flag, overrun_raw_flag};
    assign irq_masked_status = irq_raw_status & irq_enable_mask;
    // right-aligned word moved to the top bit
    assign tx_aligned = tx_head << (4'hf - size_m1);
    assign clk_rise = clk_sync && !clk_prev;
    assign clk_fall = !clk_sync && clk_prev;

    // Pin synchronisers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_meta <= 1'b0;
            clk_sync <= 1'b0;
            clk_prev <= 1'b0;
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
            din_meta <= 1'b0;
            din_sync <= 1'b0;
        end else begin
            clk_meta <= ser_clk_in;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
            sel_meta <= sel_n_in;
            sel_sync <= sel_meta;
            din_meta <= ser_din;
            din_sync <= din_meta;
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            size_m1 <= `SIZE_RESET;
            serial_clock_rate_factor <= `SCR_RESET;
            ctrl_enable <= 1'b0;
            ctrl_slave <= 1'b0;
            prescale_divisor <= `PRESCALE_RESET;
            irq_enable_mask <= `MASK_RESET;
        end else if (wr_en) begin
            case (addr)
                `ADDR_CTRL0: begin
                    size_m1 <= (wdata[3:0] < `SIZE_MIN) ? `SIZE_MIN : wdata[3:0];
                    serial_clock_rate_factor <= wdata[15:8];
                end
                `ADDR_CTRL1: begin
                    ctrl_enable <= wdata[`CTRL1_ENABLE];
                    if (!ctrl_enable) begin
                        ctrl_slave <= wdata[`CTRL1_SLAVE];
                    end
                end
                `ADDR_PRESCALE: prescale_divisor <= {wdata[7:1], 1'b0};
                `ADDR_MASK: irq_enable_mask <= wdata[3:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt <= 7'h00;
            half_pre <= 1'b0;
        end else if (!ctrl_enable || (prescale_divisor[7:1] == 7'h00)) begin
            pre_cnt <= 7'h00;
            half_pre <= 1'b0;
        end else if (pre_cnt == (prescale_divisor[7:1] - 7'h01)) begin
            pre_cnt <= 7'h00;
            half_pre <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 7'h01;
            half_pre <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scr_cnt <= 8'h00;
            half_tick <= 1'b0;
        end else if (!ctrl_enable) begin
            scr_cnt <= 8'h00;
            half_tick <= 1'b0;
        end else if (half_pre && (scr_cnt == serial_clock_rate_factor)) begin
            scr_cnt <= 8'h00;
            half_tick <= 1'b1;
        end else begin
            scr_cnt <= half_pre ? scr_cnt + 8'h01 : scr_cnt;
            half_tick <= 1'b0;
        end
    end

    // Shifter state machine for master and slave
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= st_idle;
            tx_shift <= 16'h0000;
            rx_shift <= 16'h0000;
            rx_word <= 16'h0000;
            bit_cnt <= 4'h0;
            need_load <= 1'b0;
            tx_pop <= 1'b0;
            rx_push <= 1'b0;
            ser_clk_out <= 1'b0;
            sel_n_out <= 1'b1;
            ser_dout <= 1'b0;
        end else begin
            tx_pop <= 1'b0;
            rx_push <= 1'b0;
            if (!ctrl_enable) begin
                state <= st_idle;
                ser_clk_out <= 1'b0;
                sel_n_out <= 1'b1;
                need_load <= 1'b0;
            end else begin
                case (state)
                    st_idle: begin
                        bit_cnt <= 4'h0;
                        rx_shift <= 16'h0000;
                        if (ctrl_slave) begin
                            if (!sel_sync) begin
                                state <= st_slave;
                                tx_shift <= tx_fifo_empty_flag ? 16'h0000 : tx_aligned;
                                ser_dout <= !tx_fifo_empty_flag && tx_aligned[15];
                                tx_pop <= !tx_fifo_empty_flag;
                            end
                        end else if (!tx_fifo_empty_flag && half_tick) begin
                            state <= st_setup;
                            tx_shift <= tx_aligned;
                            ser_dout <= tx_aligned[15];
                            tx_pop <= 1'b1;
                            sel_n_out <= 1'b0;
                        end
                    end
                    st_setup, st_low: begin
                        if (half_tick) begin
                            ser_clk_out <= 1'b1;
                            rx_shift <= {rx_shift[14:0], din_sync};
                            state <= st_high;
                        end
                    end
                    st_high: begin
                        if (half_tick) begin
                            ser_clk_out <= 1'b0;
                            if (bit_cnt == size_m1) begin
                                rx_word <= rx_shift;
                                rx_push <= 1'b1;
                                state <= st_end;
                            end else begin
                                tx_shift <= {tx_shift[14:0], 1'b0};
                                ser_dout <= tx_shift[14];
                                bit_cnt <= bit_cnt + 4'h1;
                                state <= st_low;
                            end
                        end
                    end
                    st_end: begin
                        if (half_tick) begin
                            bit_cnt <= 4'h0;
                            rx_shift <= 16'h0000;
                            if (!tx_fifo_empty_flag) begin
                                tx_shift <= tx_aligned;
                                ser_dout <= tx_aligned[15];
                                tx_pop <= 1'b1;
                                state <= st_setup;
                            end else begin
                                sel_n_out <= 1'b1;
                                state <= st_idle;
                            end
                        end
                    end
                    st_slave: begin
                        if (sel_sync) begin
                            state <= st_idle;
                            need_load <= 1'b0;
                        end else if (clk_rise) begin
                            if (bit_cnt == size_m1) begin
                                rx_word <= {rx_shift[14:0], din_sync};
                                rx_push <= 1'b1;
                                rx_shift <= 16'h0000;
                                bit_cnt <= 4'h0;
                                need_load <= 1'b1;
                            end else begin
                                rx_shift <= {rx_shift[14:0], din_sync};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end else if (clk_fall) begin
                            if (need_load) begin
                                tx_shift <= tx_fifo_empty_flag ? 16'h0000 : tx_aligned;
                                ser_dout <= !tx_fifo_empty_flag && tx_aligned[15];
                                tx_pop <= !tx_fifo_empty_flag;
                                need_load <= 1'b0;
                            end else begin
                                tx_shift <= {tx_shift[14:0], 1'b0};
                                ser_dout <= tx_shift[14];
                            end
                        end
                    end
                    default: state <= st_idle;
                endcase
            end
        end
    end

    // Pin drive enables
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ser_clk_oe <= 1'b0;
            sel_n_oe <= 1'b0;
            ser_dout_oe <= 1'b0;
        end else begin
            ser_clk_oe <= ctrl_enable && !ctrl_slave;
            sel_n_oe <= ctrl_enable && !ctrl_slave;
            ser_dout_oe <= ctrl_enable && (ctrl_slave ? !sel_sync
                : ((state != st_idle) || (half_tick && !tx_fifo_empty_flag)));
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_raw_flag <= 1'b0;
        end else if (rx_push && rx_fifo_full_flag && !rx_pop) begin
            overrun_raw_flag <= 1'b1;
        end else if (clear_wr && wdata[`CLEAR_OVERRUN]) begin
            overrun_raw_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            timeout_cnt <= 7'h00;
        end else if (!rx_fifo_not_empty_flag || rx_pop) begin
            timeout_cnt <= 7'h00;
        end else if (half_tick && (timeout_cnt != `TIMEOUT_HALF_TICKS)) begin
            timeout_cnt <= timeout_cnt + 7'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_timeout_raw_flag <= 1'b0;
        end else if (half_tick && !rx_pop && rx_fifo_not_empty_flag
                     && (timeout_cnt == (`TIMEOUT_HALF_TICKS - 7'h01))) begin
            rx_timeout_raw_flag <= 1'b1;
        end else if (clear_wr && wdata[`CLEAR_TIMEOUT]) begin
            rx_timeout_raw_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |irq_masked_status;
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (addr)
                `ADDR_CTRL0: rdata <= {16'h0000, serial_clock_rate_factor, 4'h0, size_m1};
                `ADDR_CTRL1: rdata <= {29'h0, ctrl_slave, ctrl_enable, 1'b0};
                `ADDR_DATA: rdata <= {16'h0000, rx_fifo_not_empty_flag ? rx_head : 16'h0000};
                `ADDR_STATUS: rdata <= {27'h0, controller_active_flag, rx_fifo_full_flag,
                    rx_fifo_not_empty_flag, tx_fifo_not_full_flag, tx_fifo_empty_flag};
                `ADDR_PRESCALE: rdata <= {24'h000000, prescale_divisor};
                `ADDR_MASK: rdata <= {28'h0, irq_enable_mask};
                `ADDR_RAW: rdata <= {28'h0, irq_raw_status};
                `ADDR_MASKED: rdata <= {28'h0, irq_masked_status};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule : sync_serial_fifo_regs
`default_nettype wire

// file: verilog/ssp_defs.svh
// Register map, field positions, reset values and counts of the serial port block
// How it works
// - In master mode, a word written to an empty FIFO while idle starts at the next half-bit tick.
// - Other written words queue and go out after all earlier words.
// - A data port read returns and removes the oldest received frame.
// - Short received frames read right-aligned with upper bits zero.
// - Status bit 0 is 1 when transmit FIFO is empty; resets 1.
// - Status bit 1 is 0 when transmit FIFO is full; resets 1.
// - Status bit 2 is 1 while receive FIFO holds an entry.
// - Status bit 3 is 1 when receive FIFO is full.
// - Status bit 4 is 1 while shifting or transmit FIFO not empty.
// - Prescale divisor is even, 0 to 254; bit 0 reads zero.
// - Clock divides by prescale divisor, then by the rate factor plus one.
// - In slave mode the prescale divisor does not affect shifting.
// - Frame done with receive FIFO full sets overrun; newest replaces last.
// - Receive FIFO non-empty and unread 32 bit times sets time-out.
// - Receive raw flag is 1 while receive FIFO at least half full.
// - Transmit raw flag is 1 while transmit FIFO half empty; resets 1.
// - Raw flags show conditions regardless of mask bits.
// - Mask bits enable matching conditions; they reset to zero.
// - Masked bit is raw and enable; interrupt is any masked bit.
// - Bit rate is clock over divisor times rate factor plus one.
// - Writing 1 to clear bit 0 or 1 clears overrun or time-out.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

`define ADDR_CTRL0 32'h4004_0000
`define ADDR_CTRL1 32'h4004_0004
`define ADDR_DATA 32'h4004_0008
`define ADDR_STATUS 32'h4004_000c
`define ADDR_PRESCALE 32'h4004_0010
`define ADDR_MASK 32'h4004_0014
`define ADDR_RAW 32'h4004_0018
`define ADDR_MASKED 32'h4004_001c
`define ADDR_CLEAR 32'h4004_0020

`define CTRL1_ENABLE 1
`define CTRL1_SLAVE 2
`define CLEAR_OVERRUN 0
`define CLEAR_TIMEOUT 1

`define SIZE_RESET 4'h7
`define SIZE_MIN 4'h3
`define SCR_RESET 8'h00
`define PRESCALE_RESET 8'h00
`define MASK_RESET 4'h0

`define FIFO_DEPTH 4'h8
`define FIFO_HALF 4'h4
`define TIMEOUT_BITS 32
`define TIMEOUT_HALF_TICKS 7'(2 * `TIMEOUT_BITS)

`endif

// file: verilog/ssp_pkg.sv
// Types shared by the serial port block
package ssp_pkg;
    typedef enum logic [2:0] {
        st_idle,
        st_setup,
        st_high,
        st_low,
        st_end,
        st_slave
    } ser_state_e;
endpackage : ssp_pkg

// file: verilog/sync_fifo.sv
// Eight-word FIFO with overwrite of the newest word when full
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defs.svh"
module sync_fifo (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Write side
    input wire logic push,
    input wire logic [15:0] push_data,
    // Read side
    input wire logic pop,
    output logic [15:0] head,
    output logic [3:0] count
);
    logic [15:0] mem [0:7];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic full;
    logic do_push;
    logic do_pop;

    assign full = (count == `FIFO_DEPTH);
    assign do_pop = pop && (count != 4'h0);
    assign do_push = push && (!full || do_pop);
    assign head = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end else if (push) begin
            mem[wr_ptr - 3'h1] <= push_data;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count <= 4'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            if (do_push && !do_pop) begin
                count <= count + 4'h1;
            end else if (do_pop && !do_push) begin
                count <= count - 4'h1;
            end
        end
    end
endmodule : sync_fifo
`default_nettype wire

// file: test/ssp_checker.sv
// Port-level checks of the serial port block
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_checker (
    // Clock, reset and register port
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [31:0] addr,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    // Serial pins and interrupt
    input wire logic ser_clk_out,
    input wire logic sel_n_out,
    input wire logic sel_n_oe,
    input wire logic ser_dout,
    input wire logic ser_dout_oe,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic rd_q;
    logic [31:0] a_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_q <= 1'b0;
            a_q <= 32'h0;
        end else begin
            rd_q <= rd_en;
            a_q <= addr;
        end
    end
    property p_rdata_idle; !rd_q |-> rdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
    property p_status; rd_q && a_q == `ADDR_STATUS |-> rdata[31:5] == 27'h0
        && (!rdata[0] || rdata[1]) && (!rdata[3] || rdata[2]); endproperty
    a_status: assert property (p_status) else $error("status flags inconsistent");
    property p_even; rd_q && a_q == `ADDR_PRESCALE |-> rdata[0] == 1'b0
        && rdata[31:8] == 24'h0; endproperty
    a_even: assert property (p_even) else $error("prescale bit 0 set");
    property p_irq; rd_q && a_q == `ADDR_MASKED |-> irq == (rdata[3:0] != 4'h0); endproperty
    a_irq: assert property (p_irq) else $error("irq differs from masked");
    property p_idle_sel; rd_q && a_q == `ADDR_STATUS && !rdata[4] && sel_n_oe
        |-> ##[0:6] sel_n_out; endproperty
    a_idle_sel: assert property (p_idle_sel) else $error("select low when idle");
    property p_clk_idle; sel_n_out |-> !ser_clk_out; endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock high outside frame");
    property p_half; $rose(ser_clk_out) |=> ser_clk_out [*3] ##1 !ser_clk_out; endproperty
    a_half: assert property (p_half) else $error("half bit length wrong");
    property p_dout_hold; $rose(ser_clk_out) |-> $stable(ser_dout); endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("data moved at capture");
    property p_dout_oe; !sel_n_out && sel_n_oe |-> ser_dout_oe; endproperty
    a_dout_oe: assert property (p_dout_oe) else $error("data pin undriven");
endmodule : ssp_checker
bind sync_serial_fifo_regs ssp_checker u_chk (.ref_clk, .reset_n, .addr, .rd_en, .rdata,
    .ser_clk_out, .sel_n_out, .sel_n_oe, .ser_dout, .ser_dout_oe, .irq);
`default_nettype wire

// file: test/spi_slave_model.sv
// Serial slave standing on the far side of the link
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
    // Link pins
    input wire logic ser_clk,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso
);
    logic [15:0] resp = 16'ha5c3;
    logic [7:0] sh = 8'h0;
    logic [7:0] w = 8'h0;
    logic [7:0] got[$];
    int n = 0;
    always @(negedge sel_n) begin
        sh = resp[7:0];
        n = 0;
    end
    always @(posedge ser_clk) begin
        w = {w[6:0], mosi};
        n++;
        if (n == 8) begin
            got.push_back(w);
            resp = resp + 16'h1111;
            n = 0;
        end
    end
    always @(negedge ser_clk) sh = (n == 0) ? resp[7:0] : sh << 1;
    // Released line shows the inverse level
    assign miso = sel_n ? ~sh[7] : sh[7];
endmodule : spi_slave_model
`default_nettype wire

// file: test/test_sync_serial_fifo_regs.sv
// Self-checking bench of the serial port block
`timescale 1ns/10ps
`default_nettype none
`include "ssp_defs.svh"
module test_sync_serial_fifo_regs;
    logic ref_clk, reset_n, wr_en, rd_en, sck, seln, mosi, miso, irq;
    logic sclk_in, sel_n_drv, sdi;
    logic [7:0] sd, cap;
    logic [31:0] addr, wdata, rdata, v;
    logic [15:0] txq[$];
    logic [15:0] rxq[$];
    logic [15:0] t;
    int error_cnt, checked, k, nf;
    sync_serial_fifo_regs uut (.ref_clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .ser_clk_in(sclk_in), .ser_clk_out(sck), .ser_clk_oe(), .sel_n_in(sel_n_drv),
        .sel_n_out(seln), .sel_n_oe(), .ser_din(sel_n_drv ? miso : sdi), .ser_dout(mosi),
        .ser_dout_oe(),
        .irq);
    spi_slave_model partner (.ser_clk(sck), .sel_n(seln), .mosi, .miso);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic send;
        t = 16'($urandom_range(255));
        wr(`ADDR_DATA, {16'h0, t});
        txq.push_back(t);
        rxq.push_back((16'ha5c3 + 16'(nf) * 16'h1111) & 16'h00ff);
        nf++;
    endtask : send
    task automatic wait_idle;
        for (k = 0; k < 400; k++) begin
            rd(`ADDR_STATUS);
            if (v[4] === 1'b0) break;
        end
        chk(32'(k < 400), 32'h1, "idle wait");
        if (k >= 400) begin
            wrap_up;
        end
    endtask : wait_idle
    // reads n words, checking each against the expected queue
    task automatic drain(input int n);
        repeat (n) begin
            rd(`ADDR_DATA);
            chk(v, {16'h0, rxq.pop_front()}, "rx word");
        end
    endtask : drain
    // slave frame of eight bits, with the bench driving the bit clock
    task automatic slave_frame(input logic [7:0] d, output logic [7:0] q);
        sel_n_drv <= 1'b0;
        repeat (12) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--) begin
            sdi <= d[i];
            repeat (6) @(posedge ref_clk);
            sclk_in <= 1'b1;
            repeat (6) @(posedge ref_clk);
            q = {q[6:0], mosi};
            sclk_in <= 1'b0;
        end
        repeat (12) @(posedge ref_clk);
        sel_n_drv <= 1'b1;
        repeat (12) @(posedge ref_clk);
    endtask : slave_frame
    task automatic wrap_up;
        $display("TB: %0d checks, %0d mismatches", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        reset_n = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        sclk_in = 1'b0;
        sel_n_drv = 1'b1;
        sdi = 1'b0;
        void'($urandom(32'hdf37));
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(`ADDR_STATUS);
        chk(v, 32'h3, "status");
        rd(`ADDR_RAW);
        chk(v, 32'h8, "raw");
        rd(`ADDR_MASK);
        chk(v, 32'h0, "mask");
        rd(32'h4004_0024);
        chk(v, 32'h0, "unmapped");
        $display("test reset done");
        wr(`ADDR_MASK, 32'h8);
        rd(`ADDR_MASKED);
        chk(v, 32'h8, "masked");
        chk({31'h0, irq}, 32'h1, "irq");
        wr(`ADDR_MASK, 32'h7);
        rd(`ADDR_MASKED);
        chk(v, 32'h0, "masked");
        chk({31'h0, irq}, 32'h0, "irq");
        wr(`ADDR_PRESCALE, 32'h5);
        rd(`ADDR_PRESCALE);
        chk(v, 32'h4, "prescale");
        wr(`ADDR_CTRL0, 32'h0107);
        wr(`ADDR_CTRL1, 32'h2);
        $display("test setup done");
        repeat (4) send;
        rd(`ADDR_STATUS);
        chk(v & 32'h11, 32'h10, "busy");
        wait_idle;
        rd(`ADDR_RAW);
        chk(v, 32'hc, "raw");
        chk({31'h0, irq}, 32'h1, "irq");
        drain(4);
        rd(`ADDR_STATUS);
        chk(v, 32'h3, "status");
        $display("test burst done");
        repeat (8) send;
        wait_idle;
        rd(`ADDR_STATUS);
        chk(v, 32'hf, "status");
        rd(`ADDR_RAW);
        chk(v & 32'h2, 32'h2, "timeout");
        wr(`ADDR_CLEAR, 32'h2);
        send;
        wait_idle;
        t = rxq.pop_back();
        void'(rxq.pop_back());
        rxq.push_back(t);
        rd(`ADDR_RAW);
        chk(v & 32'h1, 32'h1, "overrun");
        wr(`ADDR_CLEAR, 32'h1);
        rd(`ADDR_RAW);
        chk(v & 32'h1, 32'h0, "overrun");
        drain(8);
        $display("test overrun done");
        send;
        wait_idle;
        rd(`ADDR_RAW);
        chk(v & 32'h2, 32'h0, "timeout");
        repeat (300) @(posedge ref_clk);
        rd(`ADDR_RAW);
        chk(v & 32'h2, 32'h2, "timeout");
        wr(`ADDR_CLEAR, 32'h2);
        rd(`ADDR_RAW);
        chk(v & 32'h2, 32'h0, "timeout");
        drain(1);
        $display("test timeout done");
        wr(`ADDR_CTRL1, 32'h0);
        wr(`ADDR_CTRL1, 32'h4);
        wr(`ADDR_PRESCALE, 32'h0);
        wr(`ADDR_CTRL1, 32'h6);
        t = 16'($urandom_range(255));
        wr(`ADDR_DATA, {16'h0, t});
        sd = 8'($urandom_range(255));
        slave_frame(sd, cap);
        chk({24'h0, cap}, {16'h0, t}, "slave tx");
        rd(`ADDR_DATA);
        chk(v, {24'h0, sd}, "slave rx");
        $display("test slave done");
        while (txq.size() > 0) begin
            chk({24'h0, partner.got.pop_front()}, {16'h0, txq.pop_front()}, "mosi");
        end
        $display("test link order done");
        wrap_up;
    end
endmodule : test_sync_serial_fifo_regs
`default_nettype wire
